/* sysctl2_slice.sv */
// Second system control register, bits 4 and 7 to 11, with Avalon-MM slave
// How it works
// - Receive half of port B stays off until the receive enable is set.
// - Both port B enables clear puts port B in power save.
// - The second UART runs only while its enable bit is set.
// - Master select bit low means slave, high means master.
// - Master select bit also sets port B clock and frame pin directions; transmit enable sets the data pin.
// - Snooze blanking drives all zeros or all ones per polarity bit.
// - Polarity bit has no effect outside snooze.
// - Snooze fetch flag reads low, set by hardware on snooze entry.
// - While the flag is high display data comes from on-chip SRAM.
// - After snooze the flag keeps SRAM fetch in one bit per pixel.
// - CPU may write the SRAM while the flag stays set after snooze.
// - Writing zero returns fetch to the frame buffer at the second frame end after it.
// - Processor writes of one to the flag are ignored.
// - Transmit half of port B stays off until its enable is set.
`timescale 1ns/1ps
`default_nettype none
module sysctl2_slice
   import sysctl2_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // LCD controller status
   input  wire logic        lcd_snooze_pin,
   input  wire lcd_in_s     lcd_in,
   // SRAM requests
   input  wire logic        cpu_sram_req,
   input  wire logic        lcd_sram_req,
   // Control outputs
   output serial_ctl_s      serial_ctl,
   output logic             second_uart_enable,
   output logic [3:0]       lcd_data_outputs,
   output fetch_src_e       fetch_src,
   output logic             force_1bpp,
   output logic             cpu_sram_grant,
   output logic             lcd_sram_grant
);
   logic [31:0] ctrl_reg;
   logic        snz_fetch_reg;
   logic        snz_meta_reg;
   logic        snz_sync_reg;
   logic        snz_prev_reg;
   logic        ack_reg;
   logic        resync_pend_reg;
   fetch_src_e  src_reg;
   fetch_src_e  src_next;
   logic [31:0] wr_bits;
   logic        wr_hit;
   logic        flag_clear;
   logic        snz_entry;
   logic        cpu_g;
   logic        lcd_g;
   logic [31:0] read_word;

   // Byte-enabled write data
   always_comb begin
      wr_bits = ctrl_reg;
      for (int b = 0; b < 4; b++) begin
         if (avs_byteenable[b]) begin
            wr_bits[b*8 +: 8] = avs_writedata[b*8 +: 8];
         end
      end
   end

   assign wr_hit     = avs_write && !ack_reg && (avs_address == SYSCTL2_OFFSET);
   assign flag_clear = wr_hit && avs_byteenable[1] && !avs_writedata[SNZ_FETCH_BIT];
   assign snz_entry  = snz_sync_reg && !snz_prev_reg;

   // One wait cycle per access, waitrequest straight from a flop
   always_ff @(posedge clk) begin
      if (reset) begin
         ack_reg         <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         ack_reg         <= (avs_read || avs_write) && !ack_reg;
         avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
      end
   end

   // Snooze state input synchroniser
   always_ff @(posedge clk) begin
      if (reset) begin
         snz_meta_reg <= 1'b0;
         snz_sync_reg <= 1'b0;
         snz_prev_reg <= 1'b0;
      end else begin
         snz_meta_reg <= lcd_snooze_pin;
         snz_sync_reg <= snz_meta_reg;
         snz_prev_reg <= snz_sync_reg;
      end
   end

   // Control bits, only documented bits writable
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_reg <= SYSCTL2_RESET;
      end else if (wr_hit) begin
         ctrl_reg <= wr_bits & SYSCTL2_WMASK & ~(32'h1 << SNZ_FETCH_BIT);
      end
   end

   // Written ones never set the flag
   always_ff @(posedge clk) begin
      if (reset) begin
         snz_fetch_reg <= 1'b0;
      end else if (snz_entry) begin
         snz_fetch_reg <= 1'b1;
      end else if (flag_clear) begin
         snz_fetch_reg <= 1'b0;
      end
   end

   always_comb begin
      src_next = src_reg;
      case (src_reg)
         SRC_FRAME_BUFFER: begin
            if (snz_fetch_reg) begin
               src_next = SRC_SRAM_1BPP;
            end
         end
         SRC_SRAM_1BPP: begin
            if (!snz_fetch_reg) begin
               src_next = SRC_RESYNC;
            end
         end
         SRC_RESYNC: begin
            if (snz_fetch_reg) begin
               src_next = SRC_SRAM_1BPP;
            end else if (lcd_in.frame_end && resync_pend_reg) begin
               src_next = SRC_FRAME_BUFFER;
            end
         end
         default: begin
            src_next = SRC_FRAME_BUFFER;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         src_reg <= SRC_FRAME_BUFFER;
      end else begin
         src_reg <= src_next;
      end
   end

   // Frame end after the clearing write arms the resync
   always_ff @(posedge clk) begin
      if (reset) begin
         resync_pend_reg <= 1'b0;
      end else if (src_reg != SRC_RESYNC) begin
         resync_pend_reg <= 1'b0;
      end else if (lcd_in.frame_end) begin
         resync_pend_reg <= 1'b1;
      end
   end

   sram_arbiter u_arb (
      .clk       (clk),
      .reset     (reset),
      .cpu_req   (cpu_sram_req && snz_fetch_reg && !snz_sync_reg),
      .lcd_req   (lcd_sram_req),
      .cpu_grant (cpu_g),
      .lcd_grant (lcd_g)
   );

   // Read mux
   always_comb begin
      read_word = UNMAPPED_READ;
      case (avs_address)
         SYSCTL2_OFFSET: begin
            read_word = ctrl_reg;
            read_word[SNZ_FETCH_BIT] = snz_fetch_reg;
         end
         STATUS_OFFSET: begin
            read_word = {29'h0, snz_sync_reg, src_reg};
         end
         default: begin
            read_word = UNMAPPED_READ;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         avs_readdata <= UNMAPPED_READ;
      end else if (avs_read && !ack_reg) begin
         avs_readdata <= read_word;
      end
   end

   // Serial port, UART and LCD outputs
   always_ff @(posedge clk) begin
      if (reset) begin
         // Both enables clear at reset, so port B starts in power save
         serial_ctl         <= '{power_save: 1'b1, default: 1'b0};
         second_uart_enable <= 1'b0;
         lcd_data_outputs   <= LCD_ZERO;
         fetch_src          <= SRC_FRAME_BUFFER;
         force_1bpp         <= 1'b0;
         cpu_sram_grant     <= 1'b0;
         lcd_sram_grant     <= 1'b0;
      end else begin
         serial_ctl.tx_enable  <= ctrl_reg[TX_EN_BIT];
         serial_ctl.rx_enable  <= ctrl_reg[RX_EN_BIT];
         serial_ctl.power_save <= !ctrl_reg[TX_EN_BIT] && !ctrl_reg[RX_EN_BIT];
         serial_ctl.master     <= ctrl_reg[MASTER_SEL_BIT];
         serial_ctl.clk_oe     <= ctrl_reg[MASTER_SEL_BIT];
         serial_ctl.frame_oe   <= ctrl_reg[MASTER_SEL_BIT];
         serial_ctl.txd_oe     <= ctrl_reg[TX_EN_BIT];
         second_uart_enable    <= ctrl_reg[UART_EN_BIT];
         if (snz_sync_reg && lcd_in.blank) begin
            lcd_data_outputs <= ctrl_reg[SNZ_POL_BIT] ? LCD_ONES : LCD_ZERO;
         end else begin
            lcd_data_outputs <= lcd_in.pixel_data;
         end
         fetch_src      <= src_next;
         force_1bpp     <= snz_fetch_reg;
         cpu_sram_grant <= cpu_g;
         lcd_sram_grant <= lcd_g;
      end
   end

   // Checks
   sequence s_clear_write;
      wr_hit && avs_byteenable[1] && !avs_writedata[SNZ_FETCH_BIT] && !snz_entry;
   endsequence

   chk_flag_set_entry: assert property (@(posedge clk) disable iff (reset)
      snz_entry |=> snz_fetch_reg)
      else $error("flag not set on snooze entry");

   chk_flag_no_cpu_set: assert property (@(posedge clk) disable iff (reset)
      (!snz_fetch_reg && !snz_entry) |=> !snz_fetch_reg)
      else $error("flag set without snooze entry");

   chk_flag_clear_write: assert property (@(posedge clk) disable iff (reset)
      s_clear_write |=> !snz_fetch_reg)
      else $error("flag clear write lost");

   chk_resync_frame: assert property (@(posedge clk) disable iff (reset)
      (src_reg == SRC_FRAME_BUFFER && $past(src_reg) == SRC_RESYNC) |-> $past(lcd_in.frame_end))
      else $error("switch back without frame end");

   chk_sram_source: assert property (@(posedge clk) disable iff (reset)
      snz_fetch_reg |=> fetch_src == SRC_SRAM_1BPP)
      else $error("not fetching from sram");

   chk_onebpp_hold: assert property (@(posedge clk) disable iff (reset)
      snz_fetch_reg |=> force_1bpp)
      else $error("1bpp not forced");

   chk_power_save: assert property (@(posedge clk) disable iff (reset)
      (!ctrl_reg[TX_EN_BIT] && !ctrl_reg[RX_EN_BIT]) [*2] |-> serial_ctl.power_save)
      else $error("power save missing");

   chk_pin_dir: assert property (@(posedge clk) disable iff (reset)
      serial_ctl.clk_oe == serial_ctl.master)
      else $error("pin direction differs from role");

   chk_snooze_blank: assert property (@(posedge clk) disable iff (reset)
      (snz_sync_reg && lcd_in.blank && ctrl_reg[SNZ_POL_BIT] && !wr_hit)
      |=> lcd_data_outputs == LCD_ONES)
      else $error("snooze blank polarity wrong");

   chk_snooze_zero: assert property (@(posedge clk) disable iff (reset)
      (snz_sync_reg && lcd_in.blank && !ctrl_reg[SNZ_POL_BIT]) |=> lcd_data_outputs == LCD_ZERO)
      else $error("snooze blank zeros wrong");

   chk_operating_pass: assert property (@(posedge clk) disable iff (reset)
      !snz_sync_reg |=> lcd_data_outputs == $past(lcd_in.pixel_data))
      else $error("polarity applied outside snooze");

   chk_rx_follow: assert property (@(posedge clk) disable iff (reset)
      serial_ctl.rx_enable == $past(ctrl_reg[RX_EN_BIT]))
      else $error("receive enable not followed");

   chk_uart_enable: assert property (@(posedge clk) disable iff (reset)
      $rose(ctrl_reg[UART_EN_BIT]) |=> second_uart_enable)
      else $error("uart enable not followed");

   chk_arb_exclusive: assert property (@(posedge clk) disable iff (reset)
      !(cpu_sram_grant && lcd_sram_grant))
      else $error("double sram grant");

endmodule
`default_nettype wire

/* sysctl2_pkg.sv */
// Package with register map, field positions and carriers for the control slice
package sysctl2_pkg;

   localparam logic [3:0]  SYSCTL2_OFFSET    = 4'h0;
   localparam logic [3:0]  STATUS_OFFSET     = 4'h4;
   localparam int          TX_EN_BIT         = 4;
   localparam int          RX_EN_BIT         = 7;
   localparam int          UART_EN_BIT       = 8;
   localparam int          MASTER_SEL_BIT    = 9;
   localparam int          SNZ_POL_BIT       = 10;
   localparam int          SNZ_FETCH_BIT     = 11;
   localparam logic [31:0] SYSCTL2_RESET     = 32'h0000_0000;
   localparam logic [31:0] SYSCTL2_WMASK     = 32'h0000_0F90;
   localparam logic [3:0]  LCD_ZERO          = 4'h0;
   localparam logic [3:0]  LCD_ONES          = 4'hF;
   localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;

   typedef enum logic [1:0] {
      SRC_FRAME_BUFFER,
      SRC_SRAM_1BPP,
      SRC_RESYNC
   } fetch_src_e;

   typedef struct packed {
      logic tx_enable;
      logic rx_enable;
      logic power_save;
      logic master;
      logic clk_oe;
      logic frame_oe;
      logic txd_oe;
   } serial_ctl_s;

   typedef struct packed {
      logic       snooze_active;
      logic       blank;
      logic       frame_end;
      logic [3:0] pixel_data;
   } lcd_in_s;

endpackage

/* sram_arbiter.sv */
// Two-way round-robin arbiter for the on-chip SRAM, processor writes alternating with display reads
`timescale 1ns/1ps
`default_nettype none
module sram_arbiter
   import sysctl2_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Requests
   input  wire logic cpu_req,
   input  wire logic lcd_req,
   // Grants
   output logic      cpu_grant,
   output logic      lcd_grant
);
   logic last_cpu_reg;

   always_comb begin
      cpu_grant = cpu_req && (!lcd_req || !last_cpu_reg);
      lcd_grant = lcd_req && !cpu_grant;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         last_cpu_reg <= 1'b0;
      end else if (cpu_grant || lcd_grant) begin
         last_cpu_reg <= cpu_grant;
      end
   end

endmodule
`default_nettype wire

/* sysctl2_slice_bench.sv */
// Self-checking bench for the second system control register slice
`timescale 1ns/1ps
`default_nettype none
module sysctl2_slice_bench
   import sysctl2_pkg::*;
;
   logic        clk;
   logic        reset;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        lcd_snooze_pin;
   lcd_in_s     lcd_in;
   logic        cpu_sram_req;
   logic        lcd_sram_req;
   serial_ctl_s serial_ctl;
   logic        second_uart_enable;
   logic [3:0]  lcd_data_outputs;
   fetch_src_e  fetch_src;
   logic        force_1bpp;
   logic        cpu_sram_grant;
   logic        lcd_sram_grant;
   int          err_count;
   int          check_count;
   logic [31:0] rd;
   logic [31:0] v;
   logic [31:0] vals [7] = '{32'h0, 32'h80, 32'h10, 32'h90, 32'h100, 32'h200, 32'hFFFF_FFFF};

   sysctl2_slice u_sysctl2_slice (
      .clk                (clk),
      .reset              (reset),
      .avs_address        (avs_address),
      .avs_read           (avs_read),
      .avs_write          (avs_write),
      .avs_writedata      (avs_writedata),
      .avs_byteenable     (avs_byteenable),
      .avs_readdata       (avs_readdata),
      .avs_waitrequest    (avs_waitrequest),
      .lcd_snooze_pin     (lcd_snooze_pin),
      .lcd_in             (lcd_in),
      .cpu_sram_req       (cpu_sram_req),
      .lcd_sram_req       (lcd_sram_req),
      .serial_ctl         (serial_ctl),
      .second_uart_enable (second_uart_enable),
      .lcd_data_outputs   (lcd_data_outputs),
      .fetch_src          (fetch_src),
      .force_1bpp         (force_1bpp),
      .cpu_sram_grant     (cpu_sram_grant),
      .lcd_sram_grant     (lcd_sram_grant)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic results;
      $display("Checks %0d, errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One Avalon-MM access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= !wr;
      avs_write     <= wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         err_count++;
         results();
      end
   endtask

   task automatic frame;
      @(posedge clk);
      lcd_in.frame_end <= 1'b1;
      @(posedge clk);
      lcd_in.frame_end <= 1'b0;
   endtask

   initial begin
      err_count = 0;
      check_count = 0;
      reset = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      lcd_snooze_pin = 1'b0;
      lcd_in = '0;
      cpu_sram_req = 1'b0;
      lcd_sram_req = 1'b0;
      tick(4);
      reset <= 1'b0;
      tick(2);
      chk({29'h0, serial_ctl.rx_enable, serial_ctl.tx_enable, serial_ctl.power_save}, 32'h1);
      chk({31'h0, second_uart_enable}, 32'h0);
      // Every enable pattern, readback and derived controls
      foreach (vals[i]) begin
         v = vals[i];
         bus(1'b1, SYSCTL2_OFFSET, v);
         tick(3);
         bus(1'b0, SYSCTL2_OFFSET, 32'h0);
         chk(rd, v & 32'h0000_0790);
         chk({25'h0, serial_ctl}, {25'h0, v[4], v[7], !(v[4] | v[7]), v[9], v[9], v[9], v[4]});
         chk({31'h0, second_uart_enable}, {31'h0, v[8]});
      end
      // Unmapped place: write dropped, read zero
      bus(1'b1, 4'hC, 32'h0);
      bus(1'b0, 4'hC, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, SYSCTL2_OFFSET, 32'h0);
      chk(rd, 32'h0000_0790);
      // Snooze entry with blanking, polarity low then high
      bus(1'b1, SYSCTL2_OFFSET, 32'h0);
      lcd_in.blank <= 1'b1;
      lcd_in.pixel_data <= 4'hA;
      lcd_snooze_pin <= 1'b1;
      lcd_sram_req <= 1'b1;
      tick(8);
      bus(1'b0, SYSCTL2_OFFSET, 32'h0);
      chk(rd, 32'h0000_0800);
      chk({30'h0, fetch_src}, {30'h0, SRC_SRAM_1BPP});
      chk({28'h0, lcd_data_outputs}, {28'h0, LCD_ZERO});
      bus(1'b0, STATUS_OFFSET, 32'h0);
      chk(rd, 32'h0000_0005);
      bus(1'b1, SYSCTL2_OFFSET, 32'h0000_0C00);
      tick(3);
      chk({28'h0, lcd_data_outputs}, {28'h0, LCD_ONES});
      // Snooze exit keeps SRAM fetch at one bit per pixel
      lcd_snooze_pin <= 1'b0;
      tick(8);
      bus(1'b0, SYSCTL2_OFFSET, 32'h0);
      chk(rd, 32'h0000_0C00);
      chk({31'h0, force_1bpp}, 32'h1);
      chk({30'h0, fetch_src}, {30'h0, SRC_SRAM_1BPP});
      chk({28'h0, lcd_data_outputs}, 32'h0000_000A);
      bus(1'b1, SYSCTL2_OFFSET, 32'h0000_0800);
      tick(3);
      chk({28'h0, lcd_data_outputs}, 32'h0000_000A);
      // Processor reaches the SRAM while the flag stays set
      chk({31'h0, lcd_sram_grant}, 32'h1);
      cpu_sram_req <= 1'b1;
      for (int n = 0; n < 20 && cpu_sram_grant !== 1'b1; n++) begin
         @(posedge clk);
      end
      chk({31'h0, cpu_sram_grant}, 32'h1);
      cpu_sram_req <= 1'b0;
      // Clear flag, switch back after the second following frame
      bus(1'b1, SYSCTL2_OFFSET, 32'h0);
      tick(3);
      chk({30'h0, fetch_src}, {30'h0, SRC_RESYNC});
      frame();
      tick(3);
      chk({30'h0, fetch_src}, {30'h0, SRC_RESYNC});
      frame();
      tick(3);
      chk({30'h0, fetch_src}, {30'h0, SRC_FRAME_BUFFER});
      chk({31'h0, force_1bpp}, 32'h0);
      bus(1'b0, SYSCTL2_OFFSET, 32'h0);
      chk(rd, 32'h0);
      results();
   end
endmodule
`default_nettype wire
